// [include/apt_pkg.sv]
// Purpose: shared constants and types for the absolute position tracker
// Assumes: ref_clk at 250 MHz, synchronous active-high reset
// Notes: register offsets belong to the host controller's Avalon-MM slave
package apt_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PS_PER_MS = 1000000000;
    localparam int CYC_PER_MS = PS_PER_MS / CLK_PERIOD_PS;
    localparam int SETTLE_MIN_ADD_MS = 2;
    localparam int SETTLE_MAX_ADD_MS = 10;
    localparam int FILTER_MS_DEF = 2;
    localparam int CLEAR_HOLD_MS_DEF = 10;
    localparam int TMR_W = 32;

    // ==========================================================
    // coordinate ranges
    localparam int PULSE_W = 21;
    localparam logic [20:0] PULSES_PER_TURN = 21'h138800;
    localparam logic [20:0] PULSE_MAX = 21'h1387ff;
    localparam logic signed [15:0] TURN_MAX = 16'sh7fff;
    localparam logic signed [15:0] TURN_MIN = -16'sh8000;
    localparam logic signed [71:0] UU_MAX = 72'sh0000000007fffffff;
    localparam logic signed [71:0] UU_MIN = -72'sh000000000080000000;

    // ==========================================================
    // parameter-write unlock and battery levels (tenths of a volt)
    localparam logic [31:0] PROTECT_KEY = 32'h0000010f;
    localparam logic [31:0] INIT_CMD = 32'h00000001;
    localparam logic [7:0] BATT_MIN_TENTHS = 8'h1f;
    localparam logic [7:0] BATT_FAULT_TENTHS = 8'h1b;

    // ==========================================================
    // reset values of the device parameters
    localparam logic [31:0] GEAR_RST = 32'h00000001;
    localparam logic [31:0] HOME_RST = 32'h00000000;

    // ==========================================================
    // host controller register map (byte offsets)
    localparam logic [4:0] REG_CMD = 5'h00;
    localparam logic [4:0] REG_PSEL = 5'h04;
    localparam logic [4:0] REG_PDATA = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0c;
    localparam logic [4:0] REG_UU = 5'h10;
    localparam logic [4:0] REG_TURN = 5'h14;
    localparam logic [4:0] REG_PULSE = 5'h18;
    localparam logic [4:0] REG_BATT = 5'h1c;

    // ==========================================================
    // device parameter selectors
    typedef enum logic [2:0] {
        PAR_DIR = 3'b000,
        PAR_GEAR_A = 3'b001,
        PAR_GEAR_B = 3'b010,
        PAR_HOME = 3'b011,
        PAR_RANGE = 3'b100,
        PAR_KEY = 3'b101,
        PAR_INIT = 3'b110
    } apt_param_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETTLE = 3'b001,
        H_CLEAR = 3'b010,
        H_KEY = 3'b011,
        H_INIT = 3'b100
    } apt_host_e;

endpackage

// [include/apt_if.sv]
// Purpose: link between the position tracker and its host controller
// Assumes: all signals synchronous to ref_clk
// Notes: digital inputs flow host to device, status flows back
`timescale 1ns/1ps
interface apt_if;
    import apt_pkg::*;
    logic abs_enable;
    logic coord_clear;
    logic param_wr;
    apt_param_e param_sel;
    logic [31:0] param_data;
    logic uninitialised_fault;
    logic low_battery_fault;
    logic turn_overflow_fault;
    logic user_unit_overflow_fault;
    logic batt_at_min;
    logic [7:0] batt_level;
    logic signed [31:0] user_unit_position;
    logic signed [15:0] turn_count;
    logic [20:0] pulse_count;

    modport dev (
        input abs_enable, coord_clear, param_wr, param_sel, param_data,
        output uninitialised_fault, low_battery_fault, turn_overflow_fault,
        output user_unit_overflow_fault, batt_at_min, batt_level,
        output user_unit_position, turn_count, pulse_count
    );
    modport host (
        output abs_enable, coord_clear, param_wr, param_sel, param_data,
        input uninitialised_fault, low_battery_fault, turn_overflow_fault,
        input user_unit_overflow_fault, batt_at_min, batt_level,
        input user_unit_position, turn_count, pulse_count
    );
endinterface

// [core/apt_device.sv]
// Purpose: absolute coordinate keeper of the servo drive
// Assumes: encoder step pulses and battery level synchronous to ref_clk
// Notes: user-unit position recomputed every cycle from turns and pulses
`timescale 1ns/1ps

// Operation
// - clockwise decrements turns, counter-clockwise increments
// - turn overflow fault, cleared by coordinate reset
// - range ignore suppresses fault, turns wrap
// - 1280000 pulses per turn, 0 to 1279999
// - distance is turns times 1280000 plus pulses
// - user units: pulses times b over a plus offset
// - user-unit position is signed 32 bits
// - user-unit overflow fault, both cleared by homing
// - range ignore wraps user units without fault
// - uninitialised fault at power-on and power loss
// - position-register mode resets after homing completes
// - direction or gear change invalidates coordinates
// - enable then clear rise zeroes coordinates
// - enable recognised after filter time plus 2 ms
// - host holds clear for clear hold time
// - init write accepted only after key 271
// - parameter init refused in position-register mode
// - battery level reported in tenths, 31 minimum
// - low battery fault below 2.7 V
module apt_device
    import apt_pkg::*;
#(
    parameter int FILTER_MS = FILTER_MS_DEF,
    parameter int RECOG_CYC = (FILTER_MS + SETTLE_MIN_ADD_MS) * CYC_PER_MS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    apt_if.dev link,
    input wire logic enc_step,
    input wire logic enc_ccw,
    input wire logic position_register_mode,
    input wire logic homing_done,
    input wire logic power_lost,
    input wire logic [7:0] batt_tenths,
    output logic coord_valid
);

    // ==========================================================
    // state
    logic [20:0] pulse_q, pulse_d;
    logic signed [15:0] turn_q, turn_d;
    logic signed [31:0] uu_q;
    logic dir_cw_q;
    logic [31:0] gear_a_q, gear_b_q, home_q;
    logic range_ign_q;
    logic unlocked_q;
    logic [TMR_W-1:0] en_cnt_q;
    logic en_ok_q;
    logic clr_prev_q;
    logic uninit_q, uninit_d;
    logic turn_ovf_q, turn_ovf_d;
    logic uu_ovf_q, uu_ovf_d;
    logic low_batt_q;
    logic batt_min_q;
    logic [7:0] batt_lvl_q;
    logic valid_q;

    // ==========================================================
    // encoder stepping
    wire step_up = enc_step & enc_ccw;
    wire step_dn = enc_step & ~enc_ccw;
    wire pulse_top = pulse_q == PULSE_MAX;
    wire pulse_zero = pulse_q == '0;
    wire carry_up = step_up & pulse_top;
    wire carry_dn = step_dn & pulse_zero;
    wire turn_ovf_ev = (carry_up & (turn_q == TURN_MAX)) |
                       (carry_dn & (turn_q == TURN_MIN));

    // ==========================================================
    // parameter writes
    wire wr_dir = link.param_wr & (link.param_sel == PAR_DIR);
    wire wr_ga = link.param_wr & (link.param_sel == PAR_GEAR_A);
    wire wr_gb = link.param_wr & (link.param_sel == PAR_GEAR_B);
    wire wr_home = link.param_wr & (link.param_sel == PAR_HOME);
    wire wr_range = link.param_wr & (link.param_sel == PAR_RANGE);
    wire wr_key = link.param_wr & (link.param_sel == PAR_KEY);
    wire wr_init = link.param_wr & (link.param_sel == PAR_INIT);
    wire key_ok = wr_key & (link.param_data == PROTECT_KEY);
    // a change only counts once coordinates exist; rewriting the same value is harmless
    wire cfg_change = valid_q & ((wr_dir & (link.param_data[0] != dir_cw_q)) |
                                 (wr_ga & (link.param_data != gear_a_q)) |
                                 (wr_gb & (link.param_data != gear_b_q)));

    // ==========================================================
    // initialisation sources
    wire clr_rise = link.coord_clear & ~clr_prev_q;
    wire di_init = en_ok_q & clr_rise & ~position_register_mode;
    wire par_init = wr_init & (link.param_data == INIT_CMD) & unlocked_q &
                    ~position_register_mode;
    wire pr_init = position_register_mode & homing_done;
    wire do_init = di_init | par_init | pr_init;

    // ==========================================================
    // distance and user units
    wire signed [71:0] turn_pulses = 72'(turn_q) * $signed({51'h0, PULSES_PER_TURN});
    wire signed [71:0] distance = turn_pulses + $signed({51'h0, pulse_q});
    // a zero divisor would be undefined, so it is treated as one
    wire signed [71:0] div_a = (gear_a_q == '0) ? 72'sh1 : $signed({40'h0, gear_a_q});
    wire signed [71:0] scaled = (distance * $signed({40'h0, gear_b_q})) / div_a;
    wire signed [71:0] dir_term = dir_cw_q ? -scaled : scaled;
    wire signed [71:0] uu_full = dir_term + 72'($signed(home_q));
    wire uu_oor = (uu_full > UU_MAX) | (uu_full < UU_MIN);

    // ==========================================================
    // next-state logic
    always_comb begin
        pulse_d = pulse_q;
        if (do_init) begin
            pulse_d = '0;
        end else if (step_up) begin
            pulse_d = pulse_top ? '0 : pulse_q + 21'h1;
        end else if (step_dn) begin
            pulse_d = pulse_zero ? PULSE_MAX : pulse_q - 21'h1;
        end
    end

    always_comb begin
        turn_d = turn_q;
        if (do_init) begin
            turn_d = '0;
        end else if (carry_up) begin
            turn_d = turn_q + 16'sh1;
        end else if (carry_dn) begin
            turn_d = turn_q - 16'sh1;
        end
    end

    // the setting event wins over a clearing init in the same cycle, except for user-unit overflow, where the init wins
    assign uninit_d = power_lost | cfg_change | (uninit_q & ~do_init);
    assign turn_ovf_d = (turn_ovf_ev & ~range_ign_q) | (turn_ovf_q & ~do_init);
    assign uu_ovf_d = (uu_oor & ~range_ign_q & ~do_init) | (uu_ovf_q & ~do_init);

    // ==========================================================
    // coordinates and faults
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pulse_q <= '0;
            turn_q <= '0;
            uu_q <= '0;
            uninit_q <= 1'b1;
            turn_ovf_q <= 1'b0;
            uu_ovf_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            pulse_q <= pulse_d;
            turn_q <= turn_d;
            uu_q <= uu_full[31:0];
            uninit_q <= uninit_d;
            turn_ovf_q <= turn_ovf_d;
            uu_ovf_q <= uu_ovf_d;
            valid_q <= ~uninit_d;
        end
    end

    // ==========================================================
    // parameters and unlock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dir_cw_q <= 1'b0;
            gear_a_q <= GEAR_RST;
            gear_b_q <= GEAR_RST;
            home_q <= HOME_RST;
            range_ign_q <= 1'b0;
            unlocked_q <= 1'b0;
        end else begin
            if (wr_dir) begin
                dir_cw_q <= link.param_data[0];
            end
            if (wr_ga) begin
                gear_a_q <= link.param_data;
            end
            if (wr_gb) begin
                gear_b_q <= link.param_data;
            end
            if (wr_home) begin
                home_q <= link.param_data;
            end
            if (wr_range) begin
                range_ign_q <= link.param_data[0];
            end
            // any other write relocks, so a stray init write cannot reset coordinates
            if (link.param_wr) begin
                unlocked_q <= key_ok;
            end
        end
    end

    // ==========================================================
    // enable recognition and clear edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            en_cnt_q <= '0;
            en_ok_q <= 1'b0;
            clr_prev_q <= 1'b0;
        end else begin
            clr_prev_q <= link.coord_clear;
            if (!link.abs_enable) begin
                en_cnt_q <= '0;
                en_ok_q <= 1'b0;
            end else if (en_cnt_q < TMR_W'(RECOG_CYC)) begin
                en_cnt_q <= en_cnt_q + 1'b1;
            end else begin
                en_ok_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // battery monitor
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            low_batt_q <= 1'b0;
            batt_min_q <= 1'b0;
            batt_lvl_q <= '0;
        end else begin
            batt_lvl_q <= batt_tenths;
            batt_min_q <= batt_tenths <= BATT_MIN_TENTHS;
            low_batt_q <= batt_tenths < BATT_FAULT_TENTHS;
        end
    end

    // ==========================================================
    // outputs
    assign coord_valid = valid_q;
    assign link.uninitialised_fault = uninit_q;
    assign link.turn_overflow_fault = turn_ovf_q;
    assign link.user_unit_overflow_fault = uu_ovf_q;
    assign link.low_battery_fault = low_batt_q;
    assign link.batt_at_min = batt_min_q;
    assign link.batt_level = batt_lvl_q;
    assign link.user_unit_position = uu_q;
    assign link.turn_count = turn_q;
    assign link.pulse_count = pulse_q;

endmodule

// [core/apt_host.sv]
// Purpose: host controller end, drives the initialisation handshake
// Assumes: software reaches it over Avalon-MM with waitrequest
// Notes: one access completes in two cycles after the request appears
`timescale 1ns/1ps
module apt_host
    import apt_pkg::*;
#(
    parameter int FILTER_MS = FILTER_MS_DEF,
    parameter int SETTLE_CYC = (FILTER_MS + SETTLE_MAX_ADD_MS) * CYC_PER_MS,
    parameter int HOLD_CYC = CLEAR_HOLD_MS_DEF * CYC_PER_MS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    apt_if.host link,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ==========================================================
    // bus slave
    logic wait_q;
    logic [31:0] rdata_q;
    logic [2:0] psel_q;
    apt_host_e st_q;
    logic [TMR_W-1:0] tmr_q;
    logic en_q, clr_q, pwr_q;
    apt_param_e par_sel_q;
    logic [31:0] par_data_q;

    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ~wait_q;
    wire busy = st_q != H_IDLE;
    wire start_di = wr_go & (avs_address == REG_CMD) & avs_writedata[0] & ~busy;
    wire start_par = wr_go & (avs_address == REG_CMD) & avs_writedata[1] & ~busy;
    wire wr_pdata = wr_go & (avs_address == REG_PDATA) & ~busy;
    wire tmr_done = tmr_q == '0;
    wire [31:0] status = {26'h0, link.batt_at_min, busy, link.user_unit_overflow_fault,
                          link.turn_overflow_fault, link.low_battery_fault,
                          link.uninitialised_fault};

    // unmapped offsets read as zero and ignore writes
    wire [31:0] rmux =
        (avs_address == REG_PSEL) ? {29'h0, psel_q} :
        (avs_address == REG_STATUS) ? status :
        (avs_address == REG_UU) ? link.user_unit_position :
        (avs_address == REG_TURN) ? {{16{link.turn_count[15]}}, link.turn_count} :
        (avs_address == REG_PULSE) ? {11'h0, link.pulse_count} :
        (avs_address == REG_BATT) ? {24'h0, link.batt_level} : 32'h0;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            psel_q <= '0;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q) begin
                rdata_q <= rmux;
            end
            if (wr_go & (avs_address == REG_PSEL)) begin
                psel_q <= avs_writedata[2:0];
            end
        end
    end

    // ==========================================================
    // initialisation sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q <= H_IDLE;
            tmr_q <= '0;
            en_q <= 1'b0;
            clr_q <= 1'b0;
            pwr_q <= 1'b0;
            par_sel_q <= PAR_DIR;
            par_data_q <= '0;
        end else begin
            pwr_q <= 1'b0;
            if (!tmr_done) begin
                tmr_q <= tmr_q - 1'b1;
            end
            unique case (st_q)
                H_IDLE: begin
                    if (start_di) begin
                        en_q <= 1'b1;
                        tmr_q <= TMR_W'(SETTLE_CYC);
                        st_q <= H_SETTLE;
                    end else if (start_par) begin
                        pwr_q <= 1'b1;
                        par_sel_q <= PAR_KEY;
                        par_data_q <= PROTECT_KEY;
                        st_q <= H_KEY;
                    end else if (wr_pdata) begin
                        pwr_q <= 1'b1;
                        par_sel_q <= apt_param_e'(psel_q);
                        par_data_q <= avs_writedata;
                    end
                end
                H_SETTLE: begin
                    if (tmr_done) begin
                        clr_q <= 1'b1;
                        tmr_q <= TMR_W'(HOLD_CYC);
                        st_q <= H_CLEAR;
                    end
                end
                H_CLEAR: begin
                    if (tmr_done) begin
                        clr_q <= 1'b0;
                        en_q <= 1'b0;
                        st_q <= H_IDLE;
                    end
                end
                H_KEY: begin
                    pwr_q <= 1'b1;
                    par_sel_q <= PAR_INIT;
                    par_data_q <= INIT_CMD;
                    st_q <= H_INIT;
                end
                H_INIT: begin
                    st_q <= H_IDLE;
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign link.abs_enable = en_q;
    assign link.coord_clear = clr_q;
    assign link.param_wr = pwr_q;
    assign link.param_sel = par_sel_q;
    assign link.param_data = par_data_q;

endmodule

// [testbench/apt_asserts.sv]
// Purpose: concurrent checks on the link joining tracker device and host
// Assumes: one clock domain ref_clk, synchronous active-high sys_rst
// Notes: home offset and range option are shadowed from link parameter writes
`timescale 1ns/1ps
module apt_asserts
    import apt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic coord_clear,
    input wire logic param_wr,
    input wire apt_param_e param_sel,
    input wire logic [31:0] param_data,
    input wire logic uninitialised_fault,
    input wire logic low_battery_fault,
    input wire logic turn_overflow_fault,
    input wire logic user_unit_overflow_fault,
    input wire logic batt_at_min,
    input wire logic [7:0] batt_level,
    input wire logic signed [31:0] user_unit_position,
    input wire logic signed [15:0] turn_count,
    input wire logic [20:0] pulse_count
);
    // ==========================================================
    // shadow copies, updated on the same edge as the device's own
    logic [31:0] home_q;
    logic [31:0] home_d;
    logic range_q;
    logic range_d;
    assign home_d = (param_wr && param_sel == PAR_HOME) ? param_data : home_q;
    assign range_d = (param_wr && param_sel == PAR_RANGE) ? param_data[0] : range_q;
    always_ff @(posedge ref_clk) begin
        home_q <= sys_rst ? HOME_RST : home_d;
        range_q <= sys_rst ? 1'b0 : range_d;
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_pulse_range: assert property (pulse_count <= PULSE_MAX)
        else $error("pulse count beyond one turn");
    // init zeroing would look like a carry, so cycles after a clear or write are left out
    a_carry_up: assert property ($past(pulse_count) == PULSE_MAX && pulse_count == 21'h0
        && !$past(coord_clear) && !$past(param_wr) |-> turn_count == $past(turn_count) + 16'sh1)
        else $error("pulse wrap up did not carry");
    a_borrow_down: assert property ($past(pulse_count) == 21'h0
        && pulse_count == PULSE_MAX |-> turn_count == $past(turn_count) - 16'sh1)
        else $error("pulse wrap down did not borrow");
    a_turn_ovf_edge: assert property ($rose(turn_overflow_fault) |-> !range_q
        && (turn_count == TURN_MIN || turn_count == TURN_MAX))
        else $error("turn overflow raised off the range edge");
    a_uu_ovf_ignored: assert property ($rose(user_unit_overflow_fault) |-> !range_q)
        else $error("user unit overflow raised while range ignored");
    a_clear_zero: assert property ($rose(coord_clear) |=> pulse_count == 21'h0
        && turn_count == 16'sh0 && !uninitialised_fault)
        else $error("clear did not zero the coordinates");
    a_clear_home: assert property ($rose(coord_clear) |-> ##2 user_unit_position == home_q)
        else $error("clear did not load the home offset");
    a_init_needs_key: assert property (param_wr && param_sel == PAR_INIT
        && !($past(param_wr) && $past(param_sel) == PAR_KEY) && uninitialised_fault
        |=> uninitialised_fault[*2])
        else $error("init write without key accepted");
    a_batt_levels: assert property (!$past(sys_rst) |->
        batt_at_min == (batt_level <= BATT_MIN_TENTHS)
        && low_battery_fault == (batt_level < BATT_FAULT_TENTHS))
        else $error("battery flags disagree with level");
    a_power_on_uninit: assert property ($fell(sys_rst) |-> uninitialised_fault
        && !user_unit_overflow_fault && pulse_count == 21'h0)
        else $error("reset state not uninitialised");
endmodule

// [testbench/absolute_position_tracker_tb.sv]
// Purpose: self-checking bench for the tracker with host and device joined
// Assumes: recognition, settle and hold counts shortened to 20, 30 and 5
// Notes: software side speaks Avalon-MM; motion and battery drive the device
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module absolute_position_tracker_tb
    import apt_pkg::*;
;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic enc_step = 1'b0;
    logic enc_ccw = 1'b0;
    logic position_register_mode = 1'b0;
    logic homing_done = 1'b0;
    logic power_lost = 1'b0;
    logic [7:0] batt_tenths = 8'h24;
    logic [4:0] avs_address = 5'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic [31:0] rd;
    logic avs_waitrequest;
    logic coord_valid;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;

    // ==========================================================
    // structure
    apt_if link ();
    always #2 ref_clk = ~ref_clk;
    apt_device #(.RECOG_CYC(20)) i_apt_device (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(link), .enc_step(enc_step), .enc_ccw(enc_ccw),
        .position_register_mode(position_register_mode), .homing_done(homing_done),
        .power_lost(power_lost), .batt_tenths(batt_tenths), .coord_valid(coord_valid));
    apt_host #(.SETTLE_CYC(30), .HOLD_CYC(5)) i_apt_host (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(link), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    apt_asserts i_apt_asserts (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .coord_clear(link.coord_clear), .param_wr(link.param_wr), .param_sel(link.param_sel),
        .param_data(link.param_data), .uninitialised_fault(link.uninitialised_fault),
        .low_battery_fault(link.low_battery_fault), .batt_at_min(link.batt_at_min),
        .turn_overflow_fault(link.turn_overflow_fault), .batt_level(link.batt_level),
        .user_unit_overflow_fault(link.user_unit_overflow_fault),
        .user_unit_position(link.user_unit_position), .turn_count(link.turn_count),
        .pulse_count(link.pulse_count));

    // ==========================================================
    // shared tasks
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
        av(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic setpar(input apt_param_e s, input logic [31:0] d);
        av(1'b1, REG_PSEL, {29'h0, s});
        av(1'b1, REG_PDATA, d);
        repeat (3) @(posedge ref_clk);
    endtask
    // the host runs the whole handshake, so wait on its busy flag
    task automatic cmd(input logic [31:0] c);
        int n;
        n = 0;
        av(1'b1, REG_CMD, c);
        do begin
            av(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[4] !== 1'b0 && n < 60);
        `CHK(rd[4], 1'b0)
    endtask
    task automatic step(input logic ccw, input int n);
        @(posedge ref_clk);
        enc_ccw <= ccw;
        enc_step <= 1'b1;
        repeat (n) @(posedge ref_clk);
        enc_step <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic dev_pulse(input logic home);
        @(posedge ref_clk);
        homing_done <= home;
        power_lost <= !home;
        @(posedge ref_clk);
        homing_done <= 1'b0;
        power_lost <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_batt();
        logic [7:0] lv [4] = '{8'h1a, 8'h1b, 8'h1f, 8'h20};
        rdchk(REG_STATUS, 32'h1);
        `CHK(coord_valid, 1'b0)
        foreach (lv[i]) begin
            batt_tenths <= lv[i];
            repeat (3) @(posedge ref_clk);
            rdchk(REG_BATT, {24'h0, lv[i]});
            rdchk(REG_STATUS, {26'h0, lv[i] <= 8'h1f, 3'h0, lv[i] < 8'h1b, 1'b1});
        end
        batt_tenths <= 8'h24;
    endtask
    task automatic t_init_motion();
        setpar(PAR_HOME, 32'h100);
        cmd(32'h1);
        rdchk(REG_STATUS, 32'h0);
        rdchk(REG_UU, 32'h100);
        `CHK(coord_valid, 1'b1)
        step(1'b0, 1);
        rdchk(REG_PULSE, {11'h0, PULSE_MAX});
        rdchk(REG_TURN, 32'hffffffff);
        rdchk(REG_UU, 32'hff);
        step(1'b1, 2);
        rdchk(REG_TURN, 32'h0);
        rdchk(REG_UU, 32'h101);
    endtask
    task automatic t_gear_dir();
        setpar(PAR_GEAR_B, 32'h3);
        rdchk(REG_STATUS, 32'h1);
        setpar(PAR_GEAR_A, 32'h2);
        setpar(PAR_INIT, 32'h1);
        rdchk(REG_STATUS, 32'h1);
        cmd(32'h2);
        rdchk(REG_STATUS, 32'h0);
        step(1'b1, 4);
        rdchk(REG_UU, 32'h106);
        setpar(PAR_DIR, 32'h1);
        rdchk(REG_STATUS, 32'h1);
        cmd(32'h2);
        step(1'b1, 2);
        rdchk(REG_UU, 32'hfd);
    endtask
    task automatic t_overflow();
        setpar(PAR_DIR, 32'h0);
        setpar(PAR_GEAR_B, 32'h1);
        setpar(PAR_GEAR_A, 32'h1);
        setpar(PAR_HOME, 32'h7fffffff);
        cmd(32'h1);
        step(1'b1, 1);
        rdchk(REG_STATUS, 32'h8);
        position_register_mode <= 1'b1;
        dev_pulse(1'b1);
        rdchk(REG_STATUS, 32'h0);
        rdchk(REG_PULSE, 32'h0);
        dev_pulse(1'b0);
        rdchk(REG_STATUS, 32'h1);
        cmd(32'h2);
        rdchk(REG_STATUS, 32'h1);
        dev_pulse(1'b1);
        rdchk(REG_STATUS, 32'h0);
        position_register_mode <= 1'b0;
    endtask
    task automatic t_wrap();
        setpar(PAR_RANGE, 32'h1);
        cmd(32'h1);
        step(1'b1, 1);
        rdchk(REG_UU, 32'h80000000);
        rdchk(REG_STATUS, 32'h0);
        step(1'b0, 1);
        rdchk(REG_UU, 32'h7fffffff);
    endtask

    // ==========================================================
    // sequence and verdict
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // a hang anywhere ends the run here rather than running forever
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_batt();
        t_init_motion();
        t_gear_dir();
        t_overflow();
        t_wrap();
        print_verdict();
    end
endmodule
